/* File: swc_pkg.sv */
package swc_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] WKEN_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
	localparam logic [7:0] IRQ_CLR_OFS = 8'h10;
	localparam logic [7:0] IRQ_EN_OFS = 8'h14;
	// Control register fields
	localparam int CTRL_STANDBY_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int CTRL_RUNPD_BIT = 2;
	localparam int CTRL_LPSEL_BIT = 3;
	localparam int CTRL_CLRWUF_BIT = 4;
	// Status register fields
	localparam int ST_WUF_BIT = 0;
	localparam int ST_STANDBY_BIT = 1;
	localparam int ST_STOP_BIT = 2;
	localparam int ST_FLASH_ON_BIT = 3;
	localparam int ST_REG_LP_BIT = 4;
	// Interrupt events
	localparam int IRQ_WUF_BIT = 0;
	localparam int IRQ_STOP_EXIT_BIT = 1;
	localparam int IRQ_STBY_EXIT_BIT = 2;
	localparam int IRQ_W = 3;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] WKEN_RST = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;
	typedef enum logic [1:0] {
		SWC_RUN,
		SWC_STOP,
		SWC_STANDBY,
		SWC_WAKE_RESET
	} swc_state_t;
endpackage

/* File: swc_top.sv */
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/100ps
// How it works
// - Enabled wakeup sources are ORed into one rising-edge detector that sets the wakeup flag.
// - Standby entered with the wakeup flag still set is left at once.
// - Writing one to the clear-wakeup-flag bit clears the wakeup flag.
// - A source held high through the clear gives no new edge, so later events stay unseen.
// - A source still high at standby entry does not wake the device unless its edge already set the wakeup flag.
// - With flash power-down-in-run set at stop entry, flash is powered back on at stop exit.
// - Regulator goes low-power in stop when the select bit is 1, else stays in main mode.
module swc_top #(
	parameter int NUM_SRC = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_SRC-1:0] wakeup_src,
	input wire logic external_event_line,
	output logic power_reset_req,
	output logic flash_power_on,
	output logic regulator_lowpower,
	output logic standby_active,
	output logic stop_active,
	output logic irq
);
	// Local alias so vector widths below stay short
	localparam int IRQ_W_L = swc_pkg::IRQ_W;

	logic [NUM_SRC-1:0] src_meta_q;
	logic [NUM_SRC-1:0] src_sync_q;
	logic evt_meta_q;
	logic evt_sync_q;
	logic or_prev_q;
	logic wake_or;
	logic wake_edge;
	logic wakeup_flag_q;
	logic [31:0] ctrl_q;
	logic [NUM_SRC-1:0] wken_q;
	logic [IRQ_W_L-1:0] irq_stat_q;
	logic [IRQ_W_L-1:0] irq_en_q;
	logic [IRQ_W_L-1:0] irq_evt;
	logic flash_on_q;
	logic power_reset_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic wr_en;
	logic addr_ok;
	logic clear_wakeup_flag;
	logic standby_go;
	logic stop_go;
	swc_pkg::swc_state_t state_q;
	swc_pkg::swc_state_t state_d;
	logic standby_q;
	logic stop_q;
	logic reg_lp_q;
	logic lpsel_d;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == swc_pkg::CTRL_OFS) || (a == swc_pkg::WKEN_OFS) ||
			(a == swc_pkg::STATUS_OFS) || (a == swc_pkg::IRQ_STAT_OFS) ||
			(a == swc_pkg::IRQ_CLR_OFS) || (a == swc_pkg::IRQ_EN_OFS);
	endfunction

	function automatic logic wr_hit(input logic en, input logic [7:0] a,
		input logic [7:0] ofs);
		wr_hit = en && (a == ofs);
	endfunction

	// Zero wait states; every access finishes in its first access cycle
	assign pready = 1'b1;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q & psel & penable;
	assign addr_ok = is_mapped(paddr);
	assign wr_en = psel & penable & pwrite & addr_ok;

	// Pins are asynchronous to pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_meta_q <= '0;
			src_sync_q <= '0;
			evt_meta_q <= 1'b0;
			evt_sync_q <= 1'b0;
		end else begin
			src_meta_q <= wakeup_src;
			src_sync_q <= src_meta_q;
			evt_meta_q <= external_event_line;
			evt_sync_q <= evt_meta_q;
		end
	end

	// One shared detector; a level held high hides other sources
	assign wake_or = |(src_sync_q & wken_q);
	assign wake_edge = wake_or & ~or_prev_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			or_prev_q <= 1'b0;
		end else begin
			or_prev_q <= wake_or;
		end
	end

	assign clear_wakeup_flag = wr_hit(wr_en, paddr, swc_pkg::CTRL_OFS) &
		pwdata[swc_pkg::CTRL_CLRWUF_BIT];

	// Set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wakeup_flag_q <= 1'b0;
		end else if (wake_edge) begin
			wakeup_flag_q <= 1'b1;
		end else if (clear_wakeup_flag) begin
			wakeup_flag_q <= 1'b0;
		end else begin
			wakeup_flag_q <= wakeup_flag_q;
		end
	end

	// Entry requests are one-shot command bits
	assign standby_go = wr_hit(wr_en, paddr, swc_pkg::CTRL_OFS) &
		pwdata[swc_pkg::CTRL_STANDBY_BIT];
	assign stop_go = wr_hit(wr_en, paddr, swc_pkg::CTRL_OFS) &
		pwdata[swc_pkg::CTRL_STOP_BIT] & ~pwdata[swc_pkg::CTRL_STANDBY_BIT];

	// Command bits are not stored; only the two mode bits read back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= swc_pkg::CTRL_RST;
		end else if (wr_hit(wr_en, paddr, swc_pkg::CTRL_OFS)) begin
			ctrl_q <= '0;
			ctrl_q[swc_pkg::CTRL_RUNPD_BIT] <= pwdata[swc_pkg::CTRL_RUNPD_BIT];
			ctrl_q[swc_pkg::CTRL_LPSEL_BIT] <= pwdata[swc_pkg::CTRL_LPSEL_BIT];
		end
	end

	// Enables gate the sources ahead of the shared detector
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wken_q <= swc_pkg::WKEN_RST[NUM_SRC-1:0];
		end else if (wr_hit(wr_en, paddr, swc_pkg::WKEN_OFS)) begin
			wken_q <= pwdata[NUM_SRC-1:0];
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			swc_pkg::SWC_RUN: begin
				if (standby_go) begin
					state_d = swc_pkg::SWC_STANDBY;
				end else if (stop_go) begin
					state_d = swc_pkg::SWC_STOP;
				end
			end
			swc_pkg::SWC_STOP: begin
				// Sticky flag is ignored here; only a live event or edge wakes
				if (evt_sync_q || wake_edge) begin
					state_d = swc_pkg::SWC_RUN;
				end
			end
			swc_pkg::SWC_STANDBY: begin
				// Stale flag or fresh edge both end standby
				if (wakeup_flag_q || wake_edge) begin
					state_d = swc_pkg::SWC_WAKE_RESET;
				end
			end
			swc_pkg::SWC_WAKE_RESET: begin
				state_d = swc_pkg::SWC_RUN;
			end
			default: begin
				state_d = swc_pkg::SWC_RUN;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= swc_pkg::SWC_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// Standby exit always goes through a power reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_reset_q <= 1'b0;
		end else begin
			power_reset_q <= (state_q == swc_pkg::SWC_STANDBY) &&
				(state_d == swc_pkg::SWC_WAKE_RESET);
		end
	end

	// Flash stays on through run; only stop entry may drop it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_on_q <= 1'b1;
		end else if (state_q == swc_pkg::SWC_RUN && state_d == swc_pkg::SWC_STOP &&
			ctrl_q[swc_pkg::CTRL_RUNPD_BIT]) begin
			flash_on_q <= 1'b0;
		end else if (state_q == swc_pkg::SWC_STOP && state_d == swc_pkg::SWC_RUN) begin
			flash_on_q <= 1'b1;
		end
	end

	// Select bit as it stands after this edge, so a stop command
	// written together with the select takes effect at entry
	assign lpsel_d = wr_hit(wr_en, paddr, swc_pkg::CTRL_OFS) ?
		pwdata[swc_pkg::CTRL_LPSEL_BIT] : ctrl_q[swc_pkg::CTRL_LPSEL_BIT];

	// Power controls leave flops; a state decode could glitch the pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			standby_q <= 1'b0;
			stop_q <= 1'b0;
			reg_lp_q <= 1'b0;
		end else begin
			standby_q <= (state_d == swc_pkg::SWC_STANDBY);
			stop_q <= (state_d == swc_pkg::SWC_STOP);
			reg_lp_q <= (state_d == swc_pkg::SWC_STOP) && lpsel_d;
		end
	end

	assign power_reset_req = power_reset_q;
	assign flash_power_on = flash_on_q;
	assign regulator_lowpower = reg_lp_q;
	assign standby_active = standby_q;
	assign stop_active = stop_q;

	always_comb begin
		irq_evt = '0;
		irq_evt[swc_pkg::IRQ_WUF_BIT] = wake_edge;
		irq_evt[swc_pkg::IRQ_STOP_EXIT_BIT] = (state_q == swc_pkg::SWC_STOP) &&
			(state_d == swc_pkg::SWC_RUN);
		irq_evt[swc_pkg::IRQ_STBY_EXIT_BIT] = power_reset_q;
	end

	// Events win over a clear landing in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_q <= '0;
		end else if (wr_hit(wr_en, paddr, swc_pkg::IRQ_CLR_OFS)) begin
			irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W_L-1:0]) | irq_evt;
		end else begin
			irq_stat_q <= irq_stat_q | irq_evt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_q <= swc_pkg::IRQ_EN_RST;
		end else if (wr_hit(wr_en, paddr, swc_pkg::IRQ_EN_OFS)) begin
			irq_en_q <= pwdata[IRQ_W_L-1:0];
		end
	end

	// Level output; falls as soon as software clears or masks
	assign irq = |(irq_stat_q & irq_en_q);

	// Read data captured in setup, stable through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q <= '0;
			pslverr_q <= ~addr_ok;
			if (!pwrite) begin
				case (paddr)
					swc_pkg::CTRL_OFS: begin
						prdata_q <= ctrl_q;
					end
					swc_pkg::WKEN_OFS: begin
						prdata_q[NUM_SRC-1:0] <= wken_q;
					end
					swc_pkg::STATUS_OFS: begin
						prdata_q[swc_pkg::ST_WUF_BIT] <= wakeup_flag_q;
						prdata_q[swc_pkg::ST_STANDBY_BIT] <= standby_active;
						prdata_q[swc_pkg::ST_STOP_BIT] <= stop_active;
						prdata_q[swc_pkg::ST_FLASH_ON_BIT] <= flash_on_q;
						prdata_q[swc_pkg::ST_REG_LP_BIT] <= regulator_lowpower;
					end
					swc_pkg::IRQ_STAT_OFS: begin
						prdata_q[IRQ_W_L-1:0] <= irq_stat_q;
					end
					swc_pkg::IRQ_EN_OFS: begin
						prdata_q[IRQ_W_L-1:0] <= irq_en_q;
					end
					default: begin
						prdata_q <= '0;
					end
				endcase
			end
		end
	end
endmodule // swc_top

/* File: swc_pin_model.sv */
`timescale 1ns/100ps
module swc_pin_model #(
	parameter int DLY = 2
) (
	input wire logic pclk,
	input wire logic [2:0] src_req,
	input wire logic ev_req,
	output logic [2:0] wakeup_src,
	output logic external_event_line
);
	// Pins lag the request, as board wiring and slow parts would
	logic [3:0] p_q [4];
	initial foreach (p_q[i]) p_q[i] = 4'h0;
	always @(posedge pclk) begin
		p_q[0] <= {ev_req, src_req};
		for (int i = 1; i < 4; i++)
			p_q[i] <= p_q[i-1];
	end
	assign {external_event_line, wakeup_src} = p_q[DLY-1];
endmodule // swc_pin_model

/* File: swc_top_sva.sv */
`timescale 1ns/100ps
module swc_top_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pslverr,
	input wire logic power_reset_req,
	input wire logic flash_power_on,
	input wire logic regulator_lowpower,
	input wire logic standby_active,
	input wire logic stop_active,
	input wire logic external_event_line
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_lp; regulator_lowpower |-> stop_active; endproperty
	a_lp: assert property (p_lp)
		else $error("low-power regulator outside stop");
	property p_fl; !stop_active |-> flash_power_on; endproperty
	a_fl: assert property (p_fl)
		else $error("flash off outside stop");
	// Two sync stages plus the state update bound the exit
	property p_ex;
		(stop_active && external_event_line) [*3] |-> ##[1:3] !stop_active;
	endproperty
	a_ex: assert property (p_ex)
		else $error("stop not left on event");
	property p_rs; power_reset_req |-> $past(standby_active); endproperty
	a_rs: assert property (p_rs)
		else $error("power reset without standby");
	property p_pl;
		power_reset_req |=> !power_reset_req && !standby_active;
	endproperty
	a_pl: assert property (p_pl)
		else $error("power reset not a single pulse");
	property p_fe; $fell(standby_active) |-> power_reset_req; endproperty
	a_fe: assert property (p_fe)
		else $error("standby left without power reset");
	property p_mx; !(stop_active && standby_active); endproperty
	a_mx: assert property (p_mx)
		else $error("stop and standby together");
	property p_se; pslverr |-> psel && penable; endproperty
	a_se: assert property (p_se)
		else $error("error outside access phase");
	c_rst: cover property (power_reset_req);
	c_stop: cover property ($fell(stop_active));
	c_lp: cover property (regulator_lowpower);
endmodule // swc_top_sva

bind swc_top swc_top_sva u_sva (.pclk, .presetn, .psel, .penable, .pslverr,
	.power_reset_req, .flash_power_on, .regulator_lowpower,
	.standby_active, .stop_active, .external_event_line);

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
	typedef struct packed {
		logic w;
		logic [7:0] a;
		logic [31:0] d;
		logic e;
	} swc_row_t;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, ev_req = 1'h0;
	logic [2:0] src_req = 3'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, power_reset_req, flash_power_on, irq;
	logic regulator_lowpower, standby_active, stop_active;
	logic [2:0] wakeup_src;
	logic external_event_line;
	wire [2:0] pw = {stop_active, flash_power_on, regulator_lowpower};
	int err_total = 0, cmp_count = 0, k;
	// Offset 0x18 is unmapped; status ignores writes
	swc_row_t rows [15] = '{
		'{1'h0, 8'h00, 32'h0, 1'h0}, '{1'h0, 8'h04, 32'h0, 1'h0},
		'{1'h0, 8'h08, 32'h8, 1'h0}, '{1'h0, 8'h14, 32'h0, 1'h0},
		'{1'h1, 8'h00, 32'hC, 1'h0}, '{1'h0, 8'h00, 32'hC, 1'h0},
		'{1'h1, 8'h04, 32'h7, 1'h0}, '{1'h0, 8'h04, 32'h7, 1'h0},
		'{1'h1, 8'h14, 32'h7, 1'h0}, '{1'h0, 8'h14, 32'h7, 1'h0},
		'{1'h1, 8'h08, 32'hFF, 1'h0}, '{1'h0, 8'h08, 32'h8, 1'h0},
		'{1'h0, 8'h10, 32'h0, 1'h0}, '{1'h0, 8'h18, 32'h0, 1'h1},
		'{1'h1, 8'h18, 32'h0, 1'h1}};
	swc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .wakeup_src, .external_event_line,
		.power_reset_req, .flash_power_on, .regulator_lowpower,
		.standby_active, .stop_active, .irq);
	swc_pin_model u_pins (.pclk, .src_req, .ev_req, .wakeup_src,
		.external_event_line);
	always #12.5 pclk = ~pclk;
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic flag(input logic x);
		apb(1'h0, 8'h08, 32'h0);
		chk(32'(rd[0]), 32'(x));
	endtask
	task automatic wrst;
		for (k = 0; k < 12 && power_reset_req !== 1'h1; k++)
			cyc(1);
		chk(32'(power_reset_req), 32'h1);
	endtask
	task automatic test_done;
		$display("Checks %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		err_total++;
		test_done();
	end
	initial begin
		cyc(2);
		chk(prdata, 32'h0);
		chk(32'({pready, flash_power_on, irq, stop_active}), 32'hC);
		@(posedge pclk);
		presetn <= 1'h1;
		foreach (rows[j]) begin
			apb(rows[j].w, rows[j].a, rows[j].d);
			chk(32'(er), 32'(rows[j].e));
			if (!rows[j].w)
				chk(rd, rows[j].d);
		end
		apb(1'h1, 8'h04, 32'h1);
		src_req <= 3'h2;
		cyc(8);
		flag(1'h0);
		src_req <= 3'h3;
		cyc(8);
		flag(1'h1);
		chk(32'(irq), 32'h1);
		src_req <= 3'h0;
		cyc(8);
		flag(1'h1);
		apb(1'h1, 8'h14, 32'h0);
		cyc(1);
		chk(32'(irq), 32'h0);
		apb(1'h1, 8'h14, 32'h1);
		cyc(1);
		chk(32'(irq), 32'h1);
		apb(1'h1, 8'h10, 32'h1);
		cyc(1);
		chk(32'(irq), 32'h0);
		apb(1'h1, 8'h00, 32'h1C);
		flag(1'h0);
		apb(1'h1, 8'h04, 32'h5);
		src_req <= 3'h1;
		cyc(8);
		apb(1'h1, 8'h00, 32'h1C);
		src_req <= 3'h5;
		cyc(8);
		flag(1'h0);
		apb(1'h1, 8'h04, 32'h0);
		apb(1'h1, 8'h00, 32'h1C);
		apb(1'h1, 8'h04, 32'h5);
		apb(1'h1, 8'h00, 32'hD);
		wrst();
		cyc(2);
		chk(32'(standby_active), 32'h0);
		src_req <= 3'h0;
		apb(1'h1, 8'h04, 32'h1);
		cyc(8);
		apb(1'h1, 8'h00, 32'h1C);
		apb(1'h1, 8'h00, 32'hD);
		cyc(6);
		chk(32'(standby_active), 32'h1);
		src_req <= 3'h1;
		wrst();
		src_req <= 3'h0;
		apb(1'h1, 8'h00, 32'hE);
		cyc(2);
		chk(32'(pw), 32'h5);
		ev_req <= 1'h1;
		cyc(8);
		chk(32'(pw), 32'h2);
		apb(1'h0, 8'h0C, 32'h0);
		chk(rd, 32'h7);
		ev_req <= 1'h0;
		apb(1'h1, 8'h00, 32'h0);
		cyc(4);
		apb(1'h1, 8'h00, 32'h2);
		cyc(2);
		chk(32'(pw), 32'h6);
		presetn <= 1'h0;
		cyc(1);
		chk(32'(pw), 32'h2);
		test_done();
	end
endmodule // tb
